// ===== rtl/ssw_pkg.sv
/*
  Constants, types and timing counts of the supply supervisor with watchdog.
  Assumes a 25 MHz system clock; all times convert to cycles of that clock.
*/
//
// Functional notes
// - Any supply below its trip level asserts reset, in either output polarity.
// - After all supplies recover, reset stays asserted for the full timeout period.
// - When the timeout expires with no source active, reset deasserts.
// - Manual reset low asserts reset, then holds it 140ms after release.
// - Switch bounce on manual reset yields one clean reset sequence.
// - Unconnected manual reset input reads as inactive high.
// - Internal watchdog driver is low 87.5% of its period, high the rest.
// - Unconnected watchdog input gets cleared by the internal driver every 1.4s.
// - Floating or tri-stated watchdog input disables watchdog resets.
// - A low-high-low pulse on the watchdog input restarts the watchdog timer.
// - Short undervoltage dips up to 55us do not assert reset.
// - Open-drain output only pulls low and otherwise releases the line.
// - Adjustable sense input acts as a monitored supply on those variants.
// - An unserviced watchdog issues a reset with the normal timeout sequence.

package ssw_pkg;

  // ***************************************************
  // Clock and timing
  // ***************************************************
  localparam longint CLK_PERIOD_NS = 40;
  localparam longint RESET_TIMEOUT_US = 140000;   // Least time
  localparam longint WD_TIMEOUT_US = 1500000;     // Longest time
  localparam longint DRV_PERIOD_US = 1400000;     // Internal driver period
  localparam longint GLITCH_NS = 55000;           // Dip that must be ignored
  localparam longint MR_MIN_NS = 1000;            // Least manual reset pulse

  localparam int CNT_W = 26;
  localparam int FLT_W = 11;
  localparam int MR_W = 5;

  localparam longint RESET_TIMEOUT_CYC = (RESET_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;
  localparam longint WD_TIMEOUT_CYC = (WD_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam longint DRV_PERIOD_CYC = (DRV_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam logic [FLT_W-1:0] GLITCH_CYC = FLT_W'(GLITCH_NS / CLK_PERIOD_NS);
  localparam logic [MR_W-1:0] MR_MIN_CYC = MR_W'((MR_MIN_NS + CLK_PERIOD_NS - 1)
                                                  / CLK_PERIOD_NS);
  // High part of the driver starts after seven eighths of its period
  localparam logic [CNT_W-1:0] DRV_HIGH_NUM = 26'h0000007;
  localparam logic [CNT_W-1:0] DRV_HIGH_DEN = 26'h0000008;

  // ***************************************************
  // Types
  // ***************************************************
  localparam int NUM_SUPPLY = 3;

  typedef struct packed {
    logic adjustable;   // Sense input below its trip level
    logic secondary;    // Below secondary_trip_level
    logic primary;      // Below primary_trip_level
  } ssw_supply_type;

  typedef enum logic [1:0] {
    RST_ACTIVE = 2'b00,
    RST_STRETCH = 2'b01,
    RST_RELEASED = 2'b10
  } ssw_rst_state_type;

endpackage

// ===== rtl/ssw_supervisor.sv
/*
  Reset generator of the supply supervisor: undervoltage filters, manual reset
  debounce, watchdog with internal strobe driver, and the reset timeout.
  Assumes all inputs are synchronous to sys_clk; comparators are digital flags.
*/
`timescale 1ns/1ps
`default_nettype none

module ssw_supervisor #(
  parameter logic [ssw_pkg::CNT_W-1:0] RESET_TIMEOUT_CYC =
    ssw_pkg::CNT_W'(ssw_pkg::RESET_TIMEOUT_CYC),
  parameter logic [ssw_pkg::CNT_W-1:0] WD_TIMEOUT_CYC =
    ssw_pkg::CNT_W'(ssw_pkg::WD_TIMEOUT_CYC),
  parameter logic [ssw_pkg::CNT_W-1:0] DRV_PERIOD_CYC =
    ssw_pkg::CNT_W'(ssw_pkg::DRV_PERIOD_CYC)
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic ce,
  // Supply indications, high means below trip level
  input wire ssw_pkg::ssw_supply_type supply_under,
  input wire logic adjustable_enable,
  // Manual reset pin
  input wire logic manual_reset_in_low,
  input wire logic manual_reset_float,
  // Watchdog pin
  input wire logic watchdog_strobe_in,
  input wire logic watchdog_strobe_float,
  output logic watchdog_drive_out,
  // Reset outputs
  output logic reset_out_n,
  output logic reset_out_alt_polarity,
  output logic reset_od_out,
  output logic reset_od_oe_n
);

  // ***************************************************
  // Undervoltage persistence filters
  // ***************************************************
  localparam int NS = ssw_pkg::NUM_SUPPLY;
  logic [NS-1:0] uv_raw;
  logic [NS-1:0] uv_filt;
  logic [NS-1:0] next_uv_filt;
  logic [ssw_pkg::FLT_W-1:0] uv_cnt [NS];
  logic [ssw_pkg::FLT_W-1:0] next_uv_cnt [NS];

  // Adjustable input only counts on variants that have it
  assign uv_raw = {supply_under.adjustable & adjustable_enable,
                   supply_under.secondary, supply_under.primary};

  // A flag must stay set past the glitch window before it trips
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_uv
      always_comb begin
        next_uv_cnt[gi] = uv_cnt[gi];
        next_uv_filt[gi] = uv_filt[gi];
        if (!uv_raw[gi]) begin
          next_uv_cnt[gi] = '0;
          next_uv_filt[gi] = 1'b0;
        end else if (uv_cnt[gi] == ssw_pkg::GLITCH_CYC) begin
          next_uv_filt[gi] = 1'b1;
        end else begin
          next_uv_cnt[gi] = uv_cnt[gi] + 1'b1;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
          uv_cnt[gi] <= '0;
          uv_filt[gi] <= 1'b0;
        end else if (ce) begin
          uv_cnt[gi] <= next_uv_cnt[gi];
          uv_filt[gi] <= next_uv_filt[gi];
        end
      end

      a_uv_trip_delay: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(uv_filt[gi]) |-> $past(uv_cnt[gi]) == ssw_pkg::GLITCH_CYC)
        else $error("Undervoltage tripped before the glitch window");
    end
  endgenerate

  // ***************************************************
  // Manual reset debounce
  // ***************************************************
  logic mr_level;
  logic mr_low;
  logic next_mr_low;
  logic [ssw_pkg::MR_W-1:0] mr_cnt;
  logic [ssw_pkg::MR_W-1:0] next_mr_cnt;

  // The pull-up makes an open pin read high
  assign mr_level = manual_reset_float | manual_reset_in_low;

  // Level changes only after a steady run, so bounce gives one sequence
  always_comb begin
    next_mr_cnt = '0;
    next_mr_low = mr_low;
    if (mr_level == mr_low) begin
      if (mr_cnt == ssw_pkg::MR_MIN_CYC - 1'b1) begin
        next_mr_low = ~mr_low;
      end else begin
        next_mr_cnt = mr_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mr_cnt <= '0;
      mr_low <= 1'b0;
    end else if (ce) begin
      mr_cnt <= next_mr_cnt;
      mr_low <= next_mr_low;
    end
  end

  // ***************************************************
  // Internal watchdog strobe driver
  // ***************************************************
  logic [ssw_pkg::CNT_W-1:0] drv_cnt;
  logic [ssw_pkg::CNT_W-1:0] next_drv_cnt;
  logic [ssw_pkg::CNT_W-1:0] drv_high_start;
  logic next_drive;

  assign drv_high_start = ssw_pkg::CNT_W'((64'(DRV_PERIOD_CYC) * 64'(ssw_pkg::DRV_HIGH_NUM))
                                          / 64'(ssw_pkg::DRV_HIGH_DEN));

  // Free-running counter; low for seven eighths, high for the rest
  always_comb begin
    next_drv_cnt = drv_cnt + 1'b1;
    if (drv_cnt == DRV_PERIOD_CYC - 1'b1) begin
      next_drv_cnt = '0;
    end
    next_drive = (next_drv_cnt >= drv_high_start);
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      drv_cnt <= '0;
      watchdog_drive_out <= 1'b0;
    end else if (ce) begin
      drv_cnt <= next_drv_cnt;
      watchdog_drive_out <= next_drive;
    end
  end

  a_drv_duty_cycle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    watchdog_drive_out == (drv_cnt >= drv_high_start))
    else $error("Watchdog driver level does not match its phase");

  // ***************************************************
  // Watchdog timer
  // ***************************************************
  logic wdi_level;
  logic wdi_prev;
  logic wd_kick;
  logic wd_expire;
  logic next_wd_expire;
  logic reset_asserted;
  logic [ssw_pkg::CNT_W-1:0] wd_cnt;
  logic [ssw_pkg::CNT_W-1:0] next_wd_cnt;

  // A floating pin follows the internal driver, which always services it
  assign wdi_level = watchdog_strobe_float ? watchdog_drive_out
                                           : watchdog_strobe_in;
  // Falling edge closes a low-high-low pulse
  assign wd_kick = wdi_prev & ~wdi_level;

  always_comb begin
    next_wd_cnt = wd_cnt + 1'b1;
    next_wd_expire = 1'b0;
    if (reset_asserted || wd_kick) begin
      next_wd_cnt = '0;
    end else if (wd_cnt == WD_TIMEOUT_CYC - 1'b1) begin
      next_wd_cnt = '0;
      next_wd_expire = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wd_cnt <= '0;
      wd_expire <= 1'b0;
      wdi_prev <= 1'b0;
    end else if (ce) begin
      wd_cnt <= next_wd_cnt;
      wd_expire <= next_wd_expire;
      wdi_prev <= wdi_level;
    end
  end

  a_wd_kick_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ce && wd_kick |=> wd_cnt == '0)
    else $error("Watchdog pulse did not restart the timer");

  a_wd_held_reset: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ce && reset_asserted |=> wd_cnt == '0 && !wd_expire)
    else $error("Watchdog ran during reset");

  // ***************************************************
  // Reset timeout state machine
  // ***************************************************
  ssw_pkg::ssw_rst_state_type state;
  ssw_pkg::ssw_rst_state_type next_state;
  logic [ssw_pkg::CNT_W-1:0] rst_cnt;
  logic [ssw_pkg::CNT_W-1:0] next_rst_cnt;
  logic src_active;

  assign src_active = (|uv_filt) | mr_low | wd_expire;

  // Any source restarts the stretch; release only after a full quiet run
  always_comb begin
    next_state = state;
    next_rst_cnt = '0;
    unique case (state)
      ssw_pkg::RST_ACTIVE: begin
        if (!src_active) begin
          next_state = ssw_pkg::RST_STRETCH;
        end
      end
      ssw_pkg::RST_STRETCH: begin
        if (src_active) begin
          next_state = ssw_pkg::RST_ACTIVE;
        end else if (rst_cnt == RESET_TIMEOUT_CYC - 1'b1) begin
          next_state = ssw_pkg::RST_RELEASED;
        end else begin
          next_rst_cnt = rst_cnt + 1'b1;
        end
      end
      ssw_pkg::RST_RELEASED: begin
        if (src_active) begin
          next_state = ssw_pkg::RST_ACTIVE;
        end
      end
      default: begin
        next_state = ssw_pkg::RST_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= ssw_pkg::RST_ACTIVE;
      rst_cnt <= '0;
    end else if (ce) begin
      state <= next_state;
      rst_cnt <= next_rst_cnt;
    end
  end

  // Output drivers of the three variants
  assign reset_asserted = (state != ssw_pkg::RST_RELEASED);
  assign reset_out_n = ~reset_asserted;
  assign reset_out_alt_polarity = reset_asserted;
  assign reset_od_out = 1'b0;
  assign reset_od_oe_n = ~reset_asserted;

  a_src_forces_reset: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ce && src_active |=> reset_asserted)
    else $error("Active source did not hold reset");

  a_release_full_count: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(reset_asserted) |-> $past(state) == ssw_pkg::RST_STRETCH
      && $past(rst_cnt) == RESET_TIMEOUT_CYC - 1'b1)
    else $error("Reset released before the full timeout");

  a_release_on_expiry: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ce && state == ssw_pkg::RST_STRETCH && rst_cnt == RESET_TIMEOUT_CYC - 1'b1
      && !src_active |=> !reset_asserted)
    else $error("Reset not released at timeout expiry");

  a_count_cleared: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ce && src_active |=> rst_cnt == '0)
    else $error("Timeout counter not cleared by a source");

  // Expiry turns into a reset that is still held one cycle later
  sequence s_reset_held;
    reset_asserted ##1 reset_asserted;
  endsequence

  a_wd_expiry_reset: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ce && wd_expire |=> s_reset_held)
    else $error("Watchdog expiry did not issue reset");

  a_od_pull_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !reset_od_out && (reset_od_oe_n == reset_out_n)
      && (reset_out_alt_polarity != reset_out_n))
    else $error("Reset outputs disagree");

endmodule

`default_nettype wire

// ===== dv/ssw_host_model.sv
/*
  Host processor model: takes the supervisor reset and services the watchdog pin.
  Assumes the bench owns sys_clk and steers kicking and pin release.
*/
`timescale 1ns/1ps
`default_nettype none

module ssw_host_model (
  // Clock and reset seen by the host
  input wire logic sys_clk,
  input wire logic reset_out_n,
  // Bench control
  input wire logic kick_on,
  input wire logic release_pin,
  // Watchdog pin
  output logic strobe = 1'b0,
  output logic strobe_float = 1'b0
);
  // ****************************
  // Watchdog service
  // ****************************
  logic [7:0] cnt = 8'h00;

  // One-cycle high every 200 cycles, well inside 7/8 of the timeout
  always @(posedge sys_clk) begin
    cnt <= (cnt == 8'hc7 || !reset_out_n) ? 8'h00 : cnt + 8'h01;
    strobe_float <= release_pin;
    if (release_pin) begin
      strobe <= strobe_float ? strobe : ~strobe; // Released pin settles at the inverse level
    end else begin
      strobe <= kick_on && reset_out_n && cnt == 8'h64;
    end
  end
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
/*
  Self-checking bench of the supply supervisor with a host model.
  Assumes shortened timeouts: 50 reset, 400 watchdog, 320 driver cycles.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end

module tb_top;
  // ****************************
  // Stimulus and wiring
  // ****************************
  logic sys_clk, reset_n, ce, adj_en, mr_low, mr_float, kick_on, release_pin;
  ssw_pkg::ssw_supply_type su;
  logic strobe, strobe_float, drv, rst_n, rst_hi, od_out, od_oe_n;
  int failures = 0;
  int n_checks = 0;

  ssw_supervisor #(.RESET_TIMEOUT_CYC(26'h0000032), .WD_TIMEOUT_CYC(26'h0000190),
    .DRV_PERIOD_CYC(26'h0000140)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .ce(ce),
    .supply_under(su), .adjustable_enable(adj_en), .manual_reset_in_low(mr_low),
    .manual_reset_float(mr_float), .watchdog_strobe_in(strobe),
    .watchdog_strobe_float(strobe_float), .watchdog_drive_out(drv), .reset_out_n(rst_n),
    .reset_out_alt_polarity(rst_hi), .reset_od_out(od_out), .reset_od_oe_n(od_oe_n));

  ssw_host_model u_host (.sys_clk(sys_clk), .reset_out_n(rst_n), .kick_on(kick_on),
    .release_pin(release_pin), .strobe(strobe), .strobe_float(strobe_float));

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  // ****************************
  // Shared tasks
  // ****************************
  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Wait for a reset level, judging the cycle count; all outputs must agree
  task automatic wait_rst(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (rst_hi !== lvl && n <= hi) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n > hi) begin
      failures++;
      $display("CHECK FAILED t=%0t reset level never reached", $time);
      tally_and_finish();
    end
    `CHK(n >= lo, 1'b1, "reset level reached too early")
    `CHK({rst_n, od_oe_n, od_out}, {~lvl, ~lvl, 1'b0}, "reset outputs disagree")
  endtask

  // Reset must stay released for n cycles
  task automatic quiet(input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      if (rst_hi !== 1'b0 || od_oe_n !== 1'b1) bad++;
    end
    `CHK(bad, 0, "unexpected reset")
  endtask

  // ****************************
  // Scenarios
  // ****************************
  task automatic t_supply();
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      adj_en <= 1'b1;
      su <= ssw_pkg::ssw_supply_type'(3'h1 << i);
      wait_rst(1'b1, 1370, 1390);
      @(posedge sys_clk);
      su <= 3'h0;
      wait_rst(1'b0, 50, 60);
    end
    // A dip shorter than the filter is ignored
    @(posedge sys_clk);
    su <= 3'h1;
    quiet(1300);
    @(posedge sys_clk);
    su <= 3'h0;
    quiet(100);
    // Sense input is ignored on fixed-threshold variants
    @(posedge sys_clk);
    adj_en <= 1'b0;
    su <= 3'h4;
    quiet(1500);
    @(posedge sys_clk);
    su <= 3'h0;
    $display("test supply done");
  endtask

  task automatic t_manual();
    // Switch bounce shorter than the debounce gives no reset
    repeat (3) begin
      @(posedge sys_clk);
      mr_low <= 1'b0;
      quiet(10);
      @(posedge sys_clk);
      mr_low <= 1'b1;
      quiet(10);
    end
    @(posedge sys_clk);
    mr_low <= 1'b0;
    wait_rst(1'b1, 24, 30);
    repeat (80) @(posedge sys_clk);
    #1;
    `CHK(rst_hi, 1'b1, "manual reset not held")
    @(posedge sys_clk);
    mr_low <= 1'b1;
    wait_rst(1'b0, 70, 85);
    // A floating pin reads high whatever the wire shows
    @(posedge sys_clk);
    mr_float <= 1'b1;
    mr_low <= 1'b0;
    quiet(100);
    $display("test manual done");
  endtask

  task automatic t_watchdog();
    int hi;
    hi = 0;
    quiet(1500);
    @(posedge sys_clk);
    kick_on <= 1'b0;
    wait_rst(1'b1, 0, 600);
    wait_rst(1'b0, 48, 60);
    wait_rst(1'b1, 395, 410);
    wait_rst(1'b0, 48, 60);
    // Floating pin: the internal driver keeps the timer serviced
    @(posedge sys_clk);
    release_pin <= 1'b1;
    quiet(1200);
    repeat (320) begin
      @(posedge sys_clk);
      #1;
      if (drv === 1'b1) hi++;
    end
    `CHK(hi, 40, "driver high share")
    $display("test watchdog done");
  endtask

  // Enable low must freeze filters, driver and timers
  task automatic t_freeze();
    logic d0;
    int moved;
    @(posedge sys_clk);
    ce <= 1'b0;
    su <= 3'h1;
    @(posedge sys_clk);
    #1;
    d0 = drv;
    moved = 0;
    repeat (1500) begin
      @(posedge sys_clk);
      #1;
      if (rst_hi !== 1'b0 || drv !== d0) moved++;
    end
    `CHK(moved, 0, "state moved with enable low")
    @(posedge sys_clk);
    ce <= 1'b1;
    su <= 3'h0;
    quiet(400);
    $display("test freeze done");
  endtask

  // A second reset in mid-run restarts the whole sequence
  task automatic t_reset();
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK({rst_hi, drv}, 2'h2, "outputs not in reset state")
    @(posedge sys_clk);
    reset_n <= 1'b1;
    wait_rst(1'b0, 50, 60);
    quiet(400);
    $display("test reset done");
  endtask

  // ****************************
  // Main sequence
  // ****************************
  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    ce = 1'b1;
    su = 3'h0;
    adj_en = 1'b0;
    mr_low = 1'b1;
    mr_float = 1'b0;
    kick_on = 1'b1;
    release_pin = 1'b0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1;
    `CHK(rst_hi, 1'b1, "reset not asserted after power-up")
    wait_rst(1'b0, 50, 200);
    $display("test power-up done");
    t_supply();
    t_manual();
    t_watchdog();
    t_freeze();
    t_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
